// ### dsr_dac_ramp.sv
`timescale 1ns/10ps
`default_nettype none
module dsr_dac_ramp #(
  parameter int WIDTH = 8,
  parameter int STEP_CYCLES = dsr_pkg::RAMP_STEP_CYCLES
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic             rampEn,
  input  wire logic [WIDTH-1:0] staticCode,
  output var  logic [WIDTH-1:0] dacCode
);
  localparam logic [15:0] LAST_DIV = 16'(STEP_CYCLES - 1);

  typedef struct packed {
    logic [15:0]      div;
    logic [WIDTH-1:0] code;
  } dsr_ramp_t;

  dsr_ramp_t q, d;

  // Ramp wraps through the whole code range; else follow software
  always_comb begin
    d = q;
    if (!rampEn) begin
      d.div = 16'h0000;
      d.code = staticCode;
    end else if (q.div == LAST_DIV) begin
      d.div = 16'h0000;
      d.code = q.code + WIDTH'(1);
    end else begin
      d.div = q.div + 16'h0001;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dacCode = q.code;

  ramp_step_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (rampEn && $past(rampEn) && $changed(q.code))
    |-> q.code == $past(q.code) + WIDTH'(1) && $past(q.div) == LAST_DIV)
    else $error("ramp step wrong");
  ramp_wrap_c: cover property (
    @(posedge clock) disable iff (!arst_n)
    rampEn && q.code == '0 && $past(q.code) == '1);
endmodule
`default_nettype wire

// ### dsr_display_if_selftest.sv
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Continuous repeat on command, and automatic when only switches A and B closed.
// - Background and intensity DACs support a continuous ramp through their range.
// - Raster is 1024 pixels per line, 425 lines per frame, 400 visible.
// - Line rate 25.5 kHz, frame rate 60 Hz, one pixel every 55.7 ns.
module dsr_display_if_selftest (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic [3:0]  test_select_switches,
  output var  logic        selftest_trigger_n,
  output var  logic [7:0]  errorLeds,
  output var  logic        haltLed,
  output var  logic        repeatRun,
  output var  logic [7:0]  black_level_dac_out,
  output var  logic [7:0]  intensityDacOut,
  output var  logic        hsync,
  output var  logic        vsync,
  output var  logic        lineVisible
);
  typedef struct packed {
    dsr_pkg::dsr_apb_state_t st;
    logic                    pready;
    logic                    pslverr;
    logic [31:0]             prdata;
    logic [2:0]              ctrl;
    logic [8:0]              leds;
    logic [7:0]              blackCode;
    logic [7:0]              intCode;
    logic [3:0][15:0]        procReg;
    logic [3:0]              switches;
    logic                    swLatched;
    logic                    repeatRun;
    logic                    trigN;
    logic [15:0]             frameCount;
  } dsr_top_t;

  dsr_top_t q, d;
  logic     frameTick;
  logic [8:0] lineY;
  logic [32:0] rd;
  logic     wrEdge;
  logic [32:0] procHit;

  // Read decode: top bit is the address hit
  function automatic logic [32:0] readReg(
    input logic [7:0] a,
    input dsr_top_t   s,
    input logic [8:0] ln,
    input logic       vis
  );
    logic [32:0] r;
    r = 33'h000000000;
    unique case (a)
      dsr_pkg::ADDR_CTRL:   r = {1'b1, 29'h0, s.ctrl};
      dsr_pkg::ADDR_STATUS: begin
        r[32] = 1'b1;
        r[3:0] = s.switches;
        r[dsr_pkg::ST_REPEAT] = s.repeatRun;
        r[dsr_pkg::ST_VISIBLE] = vis;
        r[dsr_pkg::ST_LATCHED] = s.swLatched;
        r[dsr_pkg::ST_LINE +: 9] = ln;
      end
      dsr_pkg::ADDR_LEDS:   r = {1'b1, 23'h0, s.leds};
      dsr_pkg::ADDR_BLACK:  r = {1'b1, 24'h0, s.blackCode};
      dsr_pkg::ADDR_INTENS: r = {1'b1, 24'h0, s.intCode};
      dsr_pkg::ADDR_LATCH:  r = {1'b1, 28'h0, s.switches};
      dsr_pkg::ADDR_FRAMES: r = {1'b1, 16'h0, s.frameCount};
      default: begin
        if (a[7:4] == dsr_pkg::ADDR_PROC0[7:4]
            || a[7:4] == 4'h2) begin
          r = procRead(a, s);
        end
      end
    endcase
    return r;
  endfunction

  // Four independent processor registers, one word apart
  function automatic logic [32:0] procRead(
    input logic [7:0] a,
    input dsr_top_t   s
  );
    logic [7:0] off;
    off = a - dsr_pkg::ADDR_PROC0;
    if (a >= dsr_pkg::ADDR_PROC0 && off < 8'h10 && off[1:0] == 2'b00) begin
      return {1'b1, 16'h0, s.procReg[off[3:2]]};
    end
    return 33'h000000000;
  endfunction

  assign rd = readReg(paddr, q, lineY, lineVisible);
  assign wrEdge = (q.st == dsr_pkg::APB_ACK) && psel && penable;
  // Processor register hit, kept apart so the write path can test it
  assign procHit = procRead(paddr, q);

  // APB slave with one wait state, then block state updates
  always_comb begin
    d = q;
    d.trigN = 1'b1;
    unique case (q.st)
      dsr_pkg::APB_IDLE: begin
        d.pready = 1'b0;
        d.pslverr = 1'b0;
        if (psel && penable) begin
          d.st = dsr_pkg::APB_ACK;
          d.pready = 1'b1;
          d.pslverr = !rd[32];
          d.prdata = (pwrite || !rd[32]) ? 32'h00000000 : rd[31:0];
        end
      end
      dsr_pkg::APB_ACK: begin
        d.st = dsr_pkg::APB_IDLE;
        d.pready = 1'b0;
        d.pslverr = 1'b0;
      end
    endcase
    // Writes land only on the edge that samples pready high
    if (wrEdge && pwrite && !q.pslverr) begin
      unique case (paddr)
        dsr_pkg::ADDR_CTRL:   d.ctrl = pwdata[dsr_pkg::CTRL_W-1:0];
        dsr_pkg::ADDR_LEDS:   d.leds = pwdata[8:0];
        dsr_pkg::ADDR_BLACK:  d.blackCode = pwdata[7:0];
        dsr_pkg::ADDR_INTENS: d.intCode = pwdata[7:0];
        default: begin
          if (procHit[32]) begin
            d.procReg[paddr[3:2] - 2'b10] = pwdata[15:0];
          end
        end
      endcase
    end
    // Latch read gives a low trigger pulse for scope capture
    if (wrEdge && !pwrite && paddr == dsr_pkg::ADDR_LATCH) begin
      d.trigN = 1'b0;
    end
    // Straps are caught once, on the first edge after reset release
    if (!q.swLatched) begin
      d.switches = test_select_switches;
      d.swLatched = 1'b1;
    end
    // Repeat on command or when only A and B are closed
    d.repeatRun = q.ctrl[dsr_pkg::CTRL_CYCLE]
      || (q.swLatched && q.switches == dsr_pkg::SW_BUS_CYCLE);
    if (frameTick) begin
      d.frameCount = q.frameCount + 16'h0001;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.st <= dsr_pkg::APB_IDLE;
      q.ctrl <= dsr_pkg::CTRL_RESET;
      q.leds <= dsr_pkg::LEDS_RESET;
      q.trigN <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign selftest_trigger_n = q.trigN;
  assign errorLeds = q.leds[7:0];
  assign haltLed = q.leds[8];
  assign repeatRun = q.repeatRun;

  // Raster generator
  dsr_raster_timing uRaster (
    .clock       (clock),
    .arst_n      (arst_n),
    .hsync       (hsync),
    .vsync       (vsync),
    .lineVisible (lineVisible),
    .frameTick   (frameTick),
    .lineY       (lineY)
  );

  // Background level DAC, ramps when enabled
  dsr_dac_ramp #(
    .WIDTH       (8),
    .STEP_CYCLES (dsr_pkg::RAMP_STEP_CYCLES)
  ) uBlackRamp (
    .clock      (clock),
    .arst_n     (arst_n),
    .rampEn     (q.ctrl[dsr_pkg::CTRL_BRAMP]),
    .staticCode (q.blackCode),
    .dacCode    (black_level_dac_out)
  );

  // Intensity DAC, ramps when enabled
  dsr_dac_ramp #(
    .WIDTH       (8),
    .STEP_CYCLES (dsr_pkg::RAMP_STEP_CYCLES)
  ) uIntRamp (
    .clock      (clock),
    .arst_n     (arst_n),
    .rampEn     (q.ctrl[dsr_pkg::CTRL_IRAMP]),
    .staticCode (q.intCode),
    .dacCode    (intensityDacOut)
  );

  // Repeat, strap and bus handshake checks
  auto_repeat_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (q.swLatched && q.switches == dsr_pkg::SW_BUS_CYCLE) |=> repeatRun)
    else $error("switch repeat not raised");
  cmd_repeat_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    $rose(q.ctrl[dsr_pkg::CTRL_CYCLE]) |=> repeatRun)
    else $error("command repeat not raised");
  strap_hold_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    $past(q.swLatched) |-> $stable(q.switches))
    else $error("switches resampled");
  ready_pulse_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (psel && penable && q.st == dsr_pkg::APB_IDLE) |=> pready ##1 !pready)
    else $error("pready not one wait state");
  trig_read_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (wrEdge && !pwrite && paddr == dsr_pkg::ADDR_LATCH)
    |=> !selftest_trigger_n ##1 selftest_trigger_n)
    else $error("trigger pulse wrong");
  repeat_on_c: cover property (
    @(posedge clock) disable iff (!arst_n) $rose(repeatRun));
  trig_seen_c: cover property (
    @(posedge clock) disable iff (!arst_n) !selftest_trigger_n);
  bad_addr_c: cover property (
    @(posedge clock) disable iff (!arst_n) pready && pslverr);

  // DAC, indicator and refusal checks
  black_follow_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    !q.ctrl[dsr_pkg::CTRL_BRAMP]
    |=> black_level_dac_out == $past(q.blackCode))
    else $error("black level not following its code");
  intens_follow_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    !q.ctrl[dsr_pkg::CTRL_IRAMP]
    |=> intensityDacOut == $past(q.intCode))
    else $error("intensity not following its code");
  leds_write_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (wrEdge && pwrite && !q.pslverr && paddr == dsr_pkg::ADDR_LEDS)
    |=> {haltLed, errorLeds} == $past(pwdata[8:0]))
    else $error("indicator write lost");
  lamp_reset_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    $rose(q.swLatched) |-> {haltLed, errorLeds} == dsr_pkg::LEDS_RESET)
    else $error("indicators not all lit after reset");
  err_ready_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    pslverr |-> pready)
    else $error("error flag without ready");
  ready_single_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    pready |=> !pready)
    else $error("ready held past one cycle");
  refused_write_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (wrEdge && pwrite && q.pslverr)
    |=> $stable(q.procReg) && $stable(q.leds) && $stable(q.ctrl))
    else $error("refused write changed state");
  repeat_drop_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (q.swLatched && !q.ctrl[dsr_pkg::CTRL_CYCLE]
      && q.switches != dsr_pkg::SW_BUS_CYCLE) |=> !repeatRun)
    else $error("repeat raised without cause");
  frame_count_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    frameTick |=> q.frameCount == $past(q.frameCount) + 16'h0001)
    else $error("frame count not stepped");
endmodule
`default_nettype wire

// ### dsr_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// Host CPU side of the register bus, a plain APB master
module dsr_host_model (
  input  wire logic        clock,
  output var  logic [7:0]  paddr,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output var  logic        hung
);
  // Idle bus from time zero
  initial begin
    paddr   = 8'h00;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    pwdata  = 32'h0;
    hung    = 1'b0;
  end

  // One transfer, held until pready is seen high; bounded wait
  task automatic xfer(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] rd, output logic err);
    int n;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 64);
    hung    <= (n >= 64);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d; // Stale data must not look valid
  endtask

  // Distinct values into all four registers, then all read back;
  // a failing pass is rerun so the patterns stay on the lines
  task automatic reg_test(input logic [63:0] v,
    output logic [127:0] rb);
    logic [31:0] r;
    logic        e;
    bit          ok;
    int          t;
    ok = 1'b0;
    t = 0;
    while (!ok && t < 4) begin
      for (int k = 0; k < 4; k++) begin
        xfer(1'b1, dsr_pkg::ADDR_PROC0 + 8'(4 * k),
          {16'h0, v[16*k+:16]}, r, e);
      end
      ok = 1'b1;
      for (int k = 0; k < 4; k++) begin
        xfer(1'b0, dsr_pkg::ADDR_PROC0 + 8'(4 * k), 32'h0, r, e);
        rb[32*k+:32] = r;
        ok &= (r === {16'h0, v[16*k+:16]});
      end
      t++;
    end
  endtask

  // Walking one over the 16 data lines of one place, each step read back
  task automatic walk_one(input logic [7:0] a, output int fails);
    logic [31:0] r;
    logic        e;
    fails = 0;
    for (int k = 0; k < 16; k++) begin
      xfer(1'b1, a, 32'h1 << k, r, e);
      xfer(1'b0, a, 32'h0, r, e);
      fails += int'(r !== (32'h1 << k));
    end
  endtask

  // Address walk over 0, 1, 2, 4 ...: high byte first, then low byte
  task automatic addr_walk(output int fails);
    logic [31:0] r;
    logic        e;
    logic [15:0] ad;
    fails = 0;
    for (int j = 0; j < 16; j++) begin
      ad = (j == 0) ? 16'h0000 : 16'(1 << (j - 1));
      xfer(1'b1, dsr_pkg::ADDR_PROC0 + 8'h08, {24'h0, ad[15:8]}, r, e);
      xfer(1'b1, dsr_pkg::ADDR_PROC0 + 8'h0C, {24'h0, ad[7:0]}, r, e);
      xfer(1'b0, dsr_pkg::ADDR_PROC0 + 8'h08, 32'h0, r, e);
      fails += int'(r !== {24'h0, ad[15:8]});
      xfer(1'b0, dsr_pkg::ADDR_PROC0 + 8'h0C, 32'h0, r, e);
      fails += int'(r !== {24'h0, ad[7:0]});
    end
  endtask

  // Loop pass: trigger read first so a scope can lock onto each pass
  task automatic loop_pass(input logic [1:0] bank, output int fails);
    logic [31:0] r;
    logic        e;
    int          f;
    xfer(1'b0, dsr_pkg::ADDR_LATCH, 32'h0, r, e);
    walk_one(dsr_pkg::ADDR_PROC0 + {4'h0, bank, 2'b00}, fails);
    addr_walk(f);
    fails += f;
  endtask

  // Device indicator: one-hot first failing bank, then its failing devices
  function automatic logic [7:0] dev_code(input logic [3:0][3:0] bad);
    for (int b = 0; b < 4; b++) begin
      if (bad[b] != 4'h0) begin
        return {4'(1 << b), bad[b]};
      end
    end
    return 8'h00;
  endfunction
endmodule
`default_nettype wire

// ### dsr_pkg.sv
`default_nettype none
package dsr_pkg;
  // Register byte addresses on APB
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_LEDS   = 8'h08;
  localparam logic [7:0] ADDR_BLACK  = 8'h0C;
  localparam logic [7:0] ADDR_INTENS = 8'h10;
  localparam logic [7:0] ADDR_LATCH  = 8'h14;
  localparam logic [7:0] ADDR_PROC0  = 8'h18;
  localparam logic [7:0] ADDR_FRAMES = 8'h28;
  // Control field positions
  localparam int CTRL_CYCLE = 0;
  localparam int CTRL_BRAMP = 1;
  localparam int CTRL_IRAMP = 2;
  localparam int CTRL_W     = 3;
  // Status field positions
  localparam int ST_REPEAT  = 4;
  localparam int ST_VISIBLE = 5;
  localparam int ST_LATCHED = 6;
  localparam int ST_LINE    = 16;
  // Reset values: all indicators lit for the lamp check
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [8:0] LEDS_RESET = 9'h1FF;
  // Switch codes, bit0 = A ... bit3 = D, 1 = closed
  localparam logic [3:0] SW_BUS_CYCLE = 4'h3;
  // Raster figures
  localparam int CLK_HZ          = 40000000;
  localparam int CLK_PERIOD_PS   = 25000;
  localparam int PIXEL_PERIOD_PS = 55700;
  localparam int LINE_RATE_HZ    = 25500;
  localparam int FRAME_RATE_HZ   = 60;
  localparam int PIXELS_PER_LINE = 1024;
  localparam int LINES_PER_FRAME = 425;
  localparam int VISIBLE_LINES   = 400;
  localparam int LINE_CYCLES_MIN = CLK_HZ / LINE_RATE_HZ;
  // DAC ramp step time
  localparam int RAMP_STEP_NS     = 1000;
  localparam int RAMP_STEP_CYCLES =
    (RAMP_STEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // APB handshake states
  typedef enum logic [1:0] {
    APB_IDLE = 2'b01,
    APB_ACK  = 2'b10
  } dsr_apb_state_t;
endpackage
`default_nettype wire

// ### dsr_raster_timing.sv
`timescale 1ns/10ps
`default_nettype none
module dsr_raster_timing (
  input  wire logic       clock,
  input  wire logic       arst_n,
  output var  logic       hsync,
  output var  logic       vsync,
  output var  logic       lineVisible,
  output var  logic       frameTick,
  output var  logic [8:0] lineY
);
  localparam logic [17:0] PIX_STEP = 18'(dsr_pkg::CLK_PERIOD_PS);
  localparam logic [17:0] PIX_PER  = 18'(dsr_pkg::PIXEL_PERIOD_PS);
  localparam logic [26:0] LINE_ADD = 27'(dsr_pkg::LINE_RATE_HZ);
  localparam logic [26:0] CLK_F    = 27'(dsr_pkg::CLK_HZ);
  localparam logic [9:0]  LAST_PIX = 10'(dsr_pkg::PIXELS_PER_LINE - 1);
  localparam logic [8:0]  LAST_LN  = 9'(dsr_pkg::LINES_PER_FRAME - 1);
  localparam logic [8:0]  VIS_LN   = 9'(dsr_pkg::VISIBLE_LINES);

  typedef struct packed {
    logic [17:0] pixAcc;
    logic [26:0] lineAcc;
    logic [9:0]  pixelX;
    logic [8:0]  lineY;
    logic        pixelTick;
    logic        hsync;
    logic        vsync;
    logic        visible;
    logic        frameTick;
  } dsr_raster_t;

  dsr_raster_t q, d;
  logic [17:0] pSum;
  logic [26:0] lSum;

  // Fractional accumulators: clock is not a multiple of either rate
  always_comb begin
    d = q;
    pSum = q.pixAcc + PIX_STEP;
    lSum = q.lineAcc + LINE_ADD;
    d.pixelTick = 1'b0;
    d.hsync = 1'b0;
    d.frameTick = 1'b0;
    if (pSum >= PIX_PER) begin
      d.pixAcc = pSum - PIX_PER;
      d.pixelTick = 1'b1;
      if (q.pixelX != LAST_PIX) begin
        d.pixelX = q.pixelX + 10'h001;
      end
    end else begin
      d.pixAcc = pSum;
    end
    if (lSum >= CLK_F) begin
      d.lineAcc = lSum - CLK_F;
      d.hsync = 1'b1;
      d.pixelX = 10'h000;
      if (q.lineY == LAST_LN) begin
        d.lineY = 9'h000;
        d.frameTick = 1'b1;
      end else begin
        d.lineY = q.lineY + 9'h001;
      end
    end else begin
      d.lineAcc = lSum;
    end
    d.vsync = (d.lineY == 9'h000);
    d.visible = (d.lineY < VIS_LN);
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign hsync = q.hsync;
  assign vsync = q.vsync;
  assign lineVisible = q.visible;
  assign frameTick = q.frameTick;
  assign lineY = q.lineY;

  // Helper: cycles since last line start
  logic [11:0] lineGap;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lineGap <= 12'h000;
    end else if (q.hsync) begin
      lineGap <= 12'h001;
    end else begin
      lineGap <= lineGap + 12'h001;
    end
  end

  pixel_spacing_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    q.pixelTick |=> !q.pixelTick ##[1:2] q.pixelTick)
    else $error("pixel tick spacing wrong");
  line_period_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (q.hsync && $past(q.hsync, 1) == 1'b0 && q.lineY != 9'h001)
    |-> (lineGap == 12'(dsr_pkg::LINE_CYCLES_MIN)
      || lineGap == 12'(dsr_pkg::LINE_CYCLES_MIN + 1)))
    else $error("line period wrong");
  frame_wrap_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    q.frameTick |-> $past(q.lineY) == LAST_LN && q.lineY == 9'h000)
    else $error("frame not 425 lines");
  frame_seen_c: cover property (
    @(posedge clock) disable iff (!arst_n) q.frameTick);
endmodule
`default_nettype wire

// ### testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        clock;
  logic        arst_n;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  sw;
  logic        trigN;
  logic [7:0]  errorLeds;
  logic        haltLed;
  logic        repeatRun;
  logic [7:0]  blackDac;
  logic [7:0]  intensDac;
  logic        hsync;
  logic        vsync;
  logic        lineVisible;
  logic        hung;
  logic [31:0] rd;
  logic        err;
  int          mismatches = 0;
  int          samplesChecked = 0;

  dsr_display_if_selftest i_dsr_display_if_selftest (
    .clock(clock), .arst_n(arst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .test_select_switches(sw), .selftest_trigger_n(trigN),
    .errorLeds(errorLeds), .haltLed(haltLed), .repeatRun(repeatRun),
    .black_level_dac_out(blackDac), .intensityDacOut(intensDac),
    .hsync(hsync), .vsync(vsync), .lineVisible(lineVisible));
  dsr_host_model i_dsr_host_model (
    .clock(clock), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hung(hung));

  // 40 MHz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // A bus transfer that never completes ends the run
  always @(posedge hung) begin
    mismatches++;
    tally_and_finish();
  end

  // Repeat mode: operator command, or only A+B closed at reset
  function automatic logic expRepeat(input logic [3:0] s, input logic c);
    return c | (s == dsr_pkg::SW_BUS_CYCLE);
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_dsr_host_model.xfer(1'b1, a, d, rd, err);
  endtask

  task automatic rdx(input logic [7:0] a);
    i_dsr_host_model.xfer(1'b0, a, 32'h0, rd, err);
  endtask

  // Switches are set here while the board is held in preset
  task automatic do_reset(input logic [3:0] s);
    arst_n <= 1'b0;
    sw     <= s;
    repeat (12) @(posedge clock);
    check({trigN, repeatRun, haltLed, errorLeds}, 11'h5FF);
    arst_n <= 1'b1;
    // repeatRun settles on the second edge; look only after it
    repeat (3) @(posedge clock);
  endtask

  // Latch read gives exactly one low cycle on the trigger
  task automatic trig_check;
    int lows;
    lows = 0;
    rdx(dsr_pkg::ADDR_LATCH);
    repeat (3) begin
      @(posedge clock);
      lows += int'(trigN === 1'b0);
    end
    check(32'(lows), 32'h1);
  endtask

  task automatic wait_hsync(output int n);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hsync !== 1'b1 && n < 4000);
    if (n >= 4000) begin
      mismatches++;
      tally_and_finish();
    end
  endtask

  initial begin
    logic [3:0]   swList [10];
    logic [63:0]  v;
    logic [127:0] rb;
    logic [3:0][3:0] bad;
    logic [7:0]   c0;
    logic [8:0]   la;
    int           n;
    arst_n = 1'b0;
    sw = 4'h0;
    void'($urandom(4));
    swList = '{4'h3, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF, 4'h5, 4'h0};
    swList[8] = 4'($urandom());
    // Every forced selection, one random set, then back to normal
    for (int i = 0; i < 10; i++) begin
      do_reset(swList[i]);
      check(repeatRun, expRepeat(swList[i], 1'b0));
      rdx(dsr_pkg::ADDR_STATUS);
      check(rd[6:0], {2'b11, expRepeat(swList[i], 1'b0), swList[i]});
      trig_check();
      check(rd[3:0], swList[i]);
      sw <= ~swList[i];
      repeat (3) @(posedge clock);
      rdx(dsr_pkg::ADDR_STATUS);
      check(rd[3:0], swList[i]);
    end
    // Cycle command
    wr(dsr_pkg::ADDR_CTRL, 32'h1);
    repeat (2) @(posedge clock);
    check(repeatRun, expRepeat(4'h0, 1'b1));
    wr(dsr_pkg::ADDR_CTRL, 32'h0);
    repeat (2) @(posedge clock);
    check(repeatRun, expRepeat(4'h0, 1'b0));
    // Indicator groups, sub code 0011 first, all out last
    rdx(dsr_pkg::ADDR_LEDS);
    check(rd, 32'h1FF);
    for (int i = 0; i < 4; i++) begin
      v[8:0] = (i == 0) ? 9'h003 : (i == 3) ? 9'h000 : 9'($urandom());
      wr(dsr_pkg::ADDR_LEDS, {23'h0, v[8:0]});
      repeat (2) @(posedge clock);
      check({haltLed, errorLeds}, v[8:0]);
    end
    // Device indicator: bank 1 fails first, devices 0 and 3 in it
    bad = {4'h0, 4'hF, 4'h9, 4'h0};
    wr(dsr_pkg::ADDR_LEDS, {24'h0, i_dsr_host_model.dev_code(bad)});
    repeat (2) @(posedge clock);
    check(errorLeds, 8'h29);
    bad[0] = 4'($urandom()) | 4'h1;
    wr(dsr_pkg::ADDR_LEDS, {24'h0, i_dsr_host_model.dev_code(bad)});
    repeat (2) @(posedge clock);
    check(errorLeds, {4'h1, bad[0]});
    // One loop pass per bank, no failures expected
    for (int b = 0; b < 4; b++) begin
      i_dsr_host_model.loop_pass(2'(b), n);
      check(32'(n), 32'h0);
    end
    // Four processor registers, then a walking one
    v = {$urandom(), $urandom()};
    i_dsr_host_model.reg_test(v, rb);
    for (int k = 0; k < 4; k++) begin
      check(rb[32*k+:32], {16'h0, v[16*k+:16]});
    end
    for (int k = 0; k < 16; k++) begin
      wr(dsr_pkg::ADDR_PROC0, 32'hFFFF0000 | (32'h1 << k));
      rdx(dsr_pkg::ADDR_PROC0);
      check(rd, 32'h1 << k);
    end
    // Unmapped and misaligned places refuse; read-only ones ignore
    wr(8'h30, 32'h1);
    check(err, 1'b1);
    rdx(8'h19);
    check({err, rd[30:0]}, 32'h80000000);
    wr(dsr_pkg::ADDR_FRAMES, 32'h1234);
    check(err, 1'b0);
    rdx(dsr_pkg::ADDR_FRAMES);
    check(rd, 32'h0);
    // Static codes, then a ramp of two steps per 80 cycles
    for (int d = 0; d < 2; d++) begin
      c0 = 8'($urandom());
      wr(d ? dsr_pkg::ADDR_INTENS : dsr_pkg::ADDR_BLACK, {24'h0, c0});
      repeat (2) @(posedge clock);
      check(d ? intensDac : blackDac, c0);
      wr(dsr_pkg::ADDR_CTRL, 32'h1 << (dsr_pkg::CTRL_BRAMP + d));
      repeat (4) @(posedge clock);
      c0 = d ? intensDac : blackDac;
      repeat (80) @(posedge clock);
      check(d ? intensDac : blackDac, 8'(c0 + 8'h02));
      wr(dsr_pkg::ADDR_CTRL, 32'h0);
    end
    // Raster: line 0 flags, line period, line count steps
    do_reset(4'h0);
    check({vsync, lineVisible}, 2'b11);
    wait_hsync(n);
    repeat (4) @(posedge clock);
    check({vsync, lineVisible}, 2'b01);
    wait_hsync(n);
    wait_hsync(n);
    check(32'(n - dsr_pkg::LINE_CYCLES_MIN) <= 32'h1, 1'b1);
    rdx(dsr_pkg::ADDR_STATUS);
    la = rd[24:16];
    wait_hsync(n);
    rdx(dsr_pkg::ADDR_STATUS);
    check(rd[24:16], 9'(la + 9'h001));
    tally_and_finish();
  end
endmodule
`default_nettype wire
